// ---- shared/lsu_pkg.sv ----
`default_nettype none
package lsu_pkg;
  // APB register byte offsets
  localparam logic [7:0] LSU_CTRL_OFS = 8'h00;
  localparam logic [7:0] LSU_STAT_OFS = 8'h04;
  localparam logic [7:0] LSU_FSR_OFS = 8'h08;
  localparam logic [7:0] LSU_CSR_OFS = 8'h0c;
  // Control field positions
  localparam int LSU_CTRL_FPEN = 0;
  localparam int LSU_CTRL_CPEN = 1;
  localparam int LSU_CTRL_FQP = 2;
  localparam int LSU_CTRL_CQP = 3;
  localparam int LSU_CTRL_W = 4;
  localparam logic [3:0] LSU_CTRL_RST = 4'h0;
  // Status field positions
  localparam int LSU_STAT_CAUSE = 0;
  localparam int LSU_STAT_FTT = 4;
  localparam int LSU_STAT_BUSY = 8;
  localparam logic [31:0] LSU_FSR_RST = 32'h0000_0000;
  localparam logic [31:0] LSU_CSR_RST = 32'h0000_0000;
  // Address spaces for normal accesses
  localparam logic [7:0] LSU_ASI_USER = 8'h0a;
  localparam logic [7:0] LSU_ASI_SUPER = 8'h0b;
  // Access size codes
  localparam logic [1:0] LSU_SZ_BYTE = 2'h0;
  localparam logic [1:0] LSU_SZ_HALF = 2'h1;
  localparam logic [1:0] LSU_SZ_WORD = 2'h2;
  localparam logic [1:0] LSU_SZ_DBL = 2'h3;
  // Target unit codes
  localparam logic [2:0] LSU_U_INT = 3'h0;
  localparam logic [2:0] LSU_U_FP = 3'h1;
  localparam logic [2:0] LSU_U_FSR = 3'h2;
  localparam logic [2:0] LSU_U_FQ = 3'h3;
  localparam logic [2:0] LSU_U_CP = 3'h4;
  localparam logic [2:0] LSU_U_CSR = 3'h5;
  localparam logic [2:0] LSU_U_CQ = 3'h6;
  // Trap cause codes
  localparam logic [3:0] LSU_TC_NONE = 4'h0;
  localparam logic [3:0] LSU_TC_PRIV = 4'h1;
  localparam logic [3:0] LSU_TC_ILL = 4'h2;
  localparam logic [3:0] LSU_TC_FPDIS = 4'h3;
  localparam logic [3:0] LSU_TC_CPDIS = 4'h4;
  localparam logic [3:0] LSU_TC_ALIGN = 4'h5;
  localparam logic [3:0] LSU_TC_FPEXC = 4'h6;
  localparam logic [3:0] LSU_TC_CPEXC = 4'h7;
  localparam logic [3:0] LSU_TC_DACC = 4'h8;
  // Floating-point trap type codes
  localparam logic [2:0] LSU_FTT_NONE = 3'h0;
  localparam logic [2:0] LSU_FTT_INVREG = 3'h1;
  localparam logic [2:0] LSU_FTT_SEQ = 3'h2;
  // Register file select codes
  localparam logic [1:0] LSU_RF_INT = 2'h0;
  localparam logic [1:0] LSU_RF_FP = 2'h1;
  localparam logic [1:0] LSU_RF_CP = 2'h2;
  // Sequencer states
  typedef enum logic [3:0] {
    LSU_IDLE = 4'b0001,
    LSU_CHK = 4'b0010,
    LSU_MEM0 = 4'b0100,
    LSU_MEM1 = 4'b1000
  } lsu_state_t;
endpackage : lsu_pkg
`default_nettype wire

// ---- hdl/lsu_core.sv ----
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module lsu_core
  import lsu_pkg::*;
#(
  parameter int APB_AW = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Operation request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_store,
  input wire logic [1:0] req_size,
  input wire logic req_signed,
  input wire logic req_alt,
  input wire logic [2:0] req_unit,
  input wire logic req_use_imm,
  input wire logic req_super,
  input wire logic [31:0] src_reg_a,
  input wire logic [31:0] src_reg_b,
  input wire logic [12:0] signed_imm13,
  input wire logic [4:0] req_rd,
  input wire logic [7:0] req_asi,
  input wire logic fp_seq_err,
  input wire logic cp_seq_err,
  input wire logic fp_queue_not_empty,
  // Presence pins from outside
  input wire logic fpu_present_pin,
  input wire logic coproc_present_pin,
  // Memory system
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [7:0] mem_asi,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_access_err,
  // Register file writes
  output logic rf_we,
  output logic [1:0] rf_sel,
  output logic [4:0] rf_idx,
  output logic [31:0] rf_data,
  // Completion and trap
  output logic op_done,
  output logic trap,
  output logic [3:0] trap_cause,
  output logic [2:0] trap_ftt
);

  // Refuse an address bus too narrow for the map
  if (APB_AW < 4) begin : g_aw_chk
    $error("lsu_core: APB_AW must be at least 4");
  end

  typedef struct packed {
    lsu_state_t state;
    logic store;
    logic [1:0] size;
    logic sgn;
    logic alt;
    logic [2:0] unit;
    logic imm;
    logic sup;
    logic [4:0] rd;
    logic [31:0] addr;
    logic [7:0] asi;
    logic fseq;
    logic cseq;
    logic qne;
    logic fpu_s1;
    logic fpu_s2;
    logic cp_s1;
    logic cp_s2;
    logic [LSU_CTRL_W-1:0] ctrl;
    logic [31:0] fp_status_reg;
    logic [31:0] cp_status_reg;
    logic [3:0] cause;
    logic [2:0] ftt;
    logic mem_req;
    logic mem_we;
    logic [31:0] mem_addr;
    logic [7:0] mem_asi;
    logic rf_we;
    logic [1:0] rf_sel;
    logic [4:0] rf_idx;
    logic [31:0] rf_data;
    logic done;
    logic trap;
    logic [31:0] prdata;
    logic pslverr;
  } lsu_regs_t;

  lsu_regs_t s;
  lsu_regs_t next_s;

  // Unit group tests
  function automatic logic is_fp(input logic [2:0] u);
    is_fp = (u == LSU_U_FP) || (u == LSU_U_FSR) || (u == LSU_U_FQ);
  endfunction : is_fp

  function automatic logic is_cp(input logic [2:0] u);
    is_cp = (u == LSU_U_CP) || (u == LSU_U_CSR) || (u == LSU_U_CQ);
  endfunction : is_cp

  // Alignment test shared by loads and stores
  function automatic logic misaligned(input logic [1:0] sz,
                                      input logic [2:0] a);
    unique case (sz)
      LSU_SZ_HALF: misaligned = a[0];
      LSU_SZ_WORD: misaligned = (a[1:0] != 2'h0);
      LSU_SZ_DBL: misaligned = (a != 3'h0);
      default: misaligned = 1'b0;
    endcase
  endfunction : misaligned

  // Lane select and extension of a loaded word
  function automatic logic [31:0] load_word(input logic [1:0] sz,
                                            input logic sg,
                                            input logic [1:0] a,
                                            input logic [31:0] d);
    logic [7:0] b;
    logic [15:0] h;
    b = 8'h00;
    h = 16'h0000;
    unique case (a)
      2'h0: b = d[31:24];
      2'h1: b = d[23:16];
      2'h2: b = d[15:8];
      default: b = d[7:0];
    endcase
    h = a[1] ? d[15:0] : d[31:16];
    unique case (sz)
      LSU_SZ_BYTE: load_word = {{24{sg & b[7]}}, b};
      LSU_SZ_HALF: load_word = {{16{sg & h[15]}}, h};
      default: load_word = d;
    endcase
  endfunction : load_word

  // Register map read value
  function automatic logic [31:0] reg_read(input lsu_regs_t r,
                                           input logic [7:0] a);
    reg_read = 32'h0000_0000;
    unique case (a)
      LSU_CTRL_OFS: reg_read[LSU_CTRL_W-1:0] = r.ctrl;
      LSU_STAT_OFS: begin
        reg_read[LSU_STAT_CAUSE +: 4] = r.cause;
        reg_read[LSU_STAT_FTT +: 3] = r.ftt;
        reg_read[LSU_STAT_BUSY] = (r.state != LSU_IDLE);
      end
      LSU_FSR_OFS: reg_read = r.fp_status_reg;
      LSU_CSR_OFS: reg_read = r.cp_status_reg;
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction : reg_read

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == LSU_CTRL_OFS) || (a == LSU_STAT_OFS) ||
             (a == LSU_FSR_OFS) || (a == LSU_CSR_OFS);
  endfunction : mapped

  logic [7:0] apb_a;
  assign apb_a = 8'(paddr);

  // Next-state logic
  always_comb begin
    logic [3:0] c;
    logic [2:0] f;
    logic fpen;
    logic cpen;
    logic dbl;
    logic [31:0] w;
    c = LSU_TC_NONE;
    f = LSU_FTT_NONE;
    w = 32'h0000_0000;
    next_s = s;
    next_s.rf_we = 1'b0;
    next_s.done = 1'b0;
    next_s.trap = 1'b0;
    // Presence pins pass two flops
    next_s.fpu_s1 = fpu_present_pin;
    next_s.fpu_s2 = s.fpu_s1;
    next_s.cp_s1 = coproc_present_pin;
    next_s.cp_s2 = s.cp_s1;
    fpen = s.ctrl[LSU_CTRL_FPEN] & s.fpu_s2;
    cpen = s.ctrl[LSU_CTRL_CPEN] & s.cp_s2;
    dbl = (s.size == LSU_SZ_DBL);

    // APB read data and error captured in setup phase
    if (psel && !penable) begin
      next_s.prdata = reg_read(s, apb_a);
      next_s.pslverr = !mapped(apb_a);
    end
    // APB write in access phase
    if (psel && penable && pwrite) begin
      unique case (apb_a)
        LSU_CTRL_OFS: next_s.ctrl = pwdata[LSU_CTRL_W-1:0];
        LSU_FSR_OFS: next_s.fp_status_reg = pwdata;
        LSU_CSR_OFS: next_s.cp_status_reg = pwdata;
        default: ;
      endcase
    end

    unique case (s.state)
      LSU_IDLE: begin
        if (req_valid) begin
          next_s.store = req_store;
          next_s.size = req_size;
          next_s.sgn = req_signed;
          next_s.alt = req_alt;
          next_s.unit = req_unit;
          next_s.imm = req_use_imm;
          next_s.sup = req_super;
          next_s.rd = req_rd;
          next_s.fseq = fp_seq_err;
          next_s.cseq = cp_seq_err;
          next_s.qne = fp_queue_not_empty;
          if (req_alt) begin
            next_s.addr = src_reg_a + src_reg_b;
            next_s.asi = req_asi;
          end else begin
            next_s.addr = src_reg_a + (req_use_imm ?
              {{19{signed_imm13[12]}}, signed_imm13} : src_reg_b);
            next_s.asi = req_super ? LSU_ASI_SUPER : LSU_ASI_USER;
          end
          next_s.state = LSU_CHK;
        end
      end
      LSU_CHK: begin
        if (s.store) begin
          // Store checks in priority order
          if (!s.sup && (s.alt || s.unit == LSU_U_FQ ||
                         s.unit == LSU_U_CQ)) begin
            c = LSU_TC_PRIV;
          end else if (s.alt && s.imm) begin
            c = LSU_TC_ILL;
          end else if (is_fp(s.unit) && !fpen) begin
            c = LSU_TC_FPDIS;
          end else if (is_cp(s.unit) && !cpen) begin
            c = LSU_TC_CPDIS;
          end else if (misaligned(s.size, s.addr[2:0])) begin
            c = LSU_TC_ALIGN;
          end else if (s.unit == LSU_U_FQ &&
                       (!s.ctrl[LSU_CTRL_FQP] || !s.qne)) begin
            c = LSU_TC_FPEXC;
            f = LSU_FTT_SEQ;
          end else if (s.unit == LSU_U_CQ &&
                       !s.ctrl[LSU_CTRL_CQP]) begin
            c = LSU_TC_CPEXC;
          end
        end else begin
          // Load checks in priority order
          if (s.alt && !s.sup) begin
            c = LSU_TC_PRIV;
          end else if (s.alt && s.imm) begin
            c = LSU_TC_ILL;
          end else if (is_fp(s.unit) && !fpen) begin
            c = LSU_TC_FPDIS;
          end else if (is_cp(s.unit) && !cpen) begin
            c = LSU_TC_CPDIS;
          end else if (misaligned(s.size, s.addr[2:0])) begin
            c = LSU_TC_ALIGN;
          end else if (s.unit == LSU_U_FP && dbl && s.rd[0]) begin
            c = LSU_TC_FPEXC;
            f = LSU_FTT_INVREG;
          end else if (is_fp(s.unit) && s.fseq) begin
            c = LSU_TC_FPEXC;
            f = LSU_FTT_SEQ;
          end else if (is_cp(s.unit) && s.cseq) begin
            c = LSU_TC_CPEXC;
          end
        end
        if (c != LSU_TC_NONE) begin
          next_s.trap = 1'b1;
          next_s.cause = c;
          next_s.ftt = f;
          next_s.state = LSU_IDLE;
        end else begin
          // Memory access only without a trap
          next_s.mem_req = 1'b1;
          next_s.mem_we = s.store;
          next_s.mem_addr = s.addr;
          next_s.mem_asi = s.asi;
          next_s.state = LSU_MEM0;
        end
      end
      LSU_MEM0: begin
        if (mem_ack) begin
          next_s.mem_req = 1'b0;
          if (mem_access_err) begin
            next_s.trap = 1'b1;
            next_s.cause = LSU_TC_DACC;
            next_s.ftt = LSU_FTT_NONE;
            next_s.state = LSU_IDLE;
          end else begin
            if (!s.store) begin
              // First word write-back
              w = load_word(s.size, s.sgn, s.addr[1:0], mem_rdata);
              next_s.rf_data = w;
              next_s.rf_idx = dbl ? {s.rd[4:1], 1'b0} : s.rd;
              unique case (s.unit)
                LSU_U_INT: begin
                  next_s.rf_sel = LSU_RF_INT;
                  next_s.rf_we = dbl || (s.rd != 5'h00);
                end
                LSU_U_FP: begin
                  next_s.rf_sel = LSU_RF_FP;
                  next_s.rf_we = 1'b1;
                end
                LSU_U_CP: begin
                  next_s.rf_sel = LSU_RF_CP;
                  next_s.rf_we = 1'b1;
                end
                LSU_U_FSR: next_s.fp_status_reg = w;
                LSU_U_CSR: next_s.cp_status_reg = w;
                default: ;
              endcase
            end
            if (dbl) begin
              // Second transfer, only while no trap
              next_s.mem_req = 1'b1;
              next_s.mem_addr = s.addr + 32'h0000_0004;
              next_s.state = LSU_MEM1;
            end else begin
              next_s.done = 1'b1;
              next_s.cause = LSU_TC_NONE;
              next_s.ftt = LSU_FTT_NONE;
              next_s.state = LSU_IDLE;
            end
          end
        end
      end
      LSU_MEM1: begin
        if (mem_ack) begin
          next_s.mem_req = 1'b0;
          next_s.state = LSU_IDLE;
          if (mem_access_err) begin
            next_s.trap = 1'b1;
            next_s.cause = LSU_TC_DACC;
            next_s.ftt = LSU_FTT_NONE;
          end else begin
            next_s.done = 1'b1;
            next_s.cause = LSU_TC_NONE;
            next_s.ftt = LSU_FTT_NONE;
            if (!s.store) begin
              next_s.rf_data = mem_rdata;
              next_s.rf_idx = {s.rd[4:1], 1'b1};
              next_s.rf_sel = (s.unit == LSU_U_FP) ? LSU_RF_FP :
                              (s.unit == LSU_U_CP) ? LSU_RF_CP :
                              LSU_RF_INT;
              next_s.rf_we = 1'b1;
            end
          end
        end
      end
      default: next_s.state = LSU_IDLE;
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s <= '0;
      s.state <= LSU_IDLE;
      s.ctrl <= LSU_CTRL_RST;
      s.fp_status_reg <= LSU_FSR_RST;
      s.cp_status_reg <= LSU_CSR_RST;
      s.rf_sel <= LSU_RF_INT;
      s.cause <= LSU_TC_NONE;
      s.ftt <= LSU_FTT_NONE;
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign req_ready = (s.state == LSU_IDLE);
  assign pready = 1'b1; // No wait states
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign mem_req = s.mem_req;
  assign mem_we = s.mem_we;
  assign mem_addr = s.mem_addr;
  assign mem_asi = s.mem_asi;
  assign rf_we = s.rf_we;
  assign rf_sel = s.rf_sel;
  assign rf_idx = s.rf_idx;
  assign rf_data = s.rf_data;
  assign op_done = s.done;
  assign trap = s.trap;
  assign trap_cause = s.cause;
  assign trap_ftt = s.ftt;

endmodule : lsu_core
`default_nettype wire

// ---- bench/lsu_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsu_mem_model (
  // Clock
  input wire logic mclk,
  // Request from the core
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  // Answer to the core
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  output logic mem_access_err,
  // Latency and error placement
  input wire logic [2:0] lat,
  input wire logic [1:0] err_at
);
  logic [2:0] cnt;
  logic [1:0] nth;
  logic [31:0] tick = 32'h0;
  // Stored word, distinct in every lane
  function automatic logic [31:0] mem_word(input logic [31:0] a);
    return {a[17:2], ~a[31:16]} ^ 32'h9e37_79b9;
  endfunction : mem_word
  // Ack after lat cycles; data churns outside the ack cycle
  always @(posedge mclk) begin
    tick <= tick + 32'h1;
    mem_ack <= 1'b0;
    mem_rdata <= tick ^ 32'h5a5a_a5a5;
    mem_access_err <= tick[0];
    if (mem_req !== 1'b1) begin
      cnt <= 3'h0;
      nth <= 2'h0;
    end else if (mem_ack) begin
      cnt <= 3'h0;
      nth <= nth + 2'h1;
    end else if (cnt >= lat) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_word(mem_addr);
      mem_access_err <= (nth + 2'h1) == err_at;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end
endmodule : lsu_mem_model
`default_nettype wire

// ---- bench/lsu_core_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsu_core_chk
  import lsu_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Request
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_store,
  input wire logic req_alt,
  input wire logic req_use_imm,
  input wire logic req_super,
  input wire logic [31:0] src_reg_a,
  input wire logic [31:0] src_reg_b,
  input wire logic [12:0] signed_imm13,
  input wire logic [7:0] req_asi,
  // Memory
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [7:0] mem_asi,
  input wire logic mem_ack,
  input wire logic mem_access_err,
  // Results
  input wire logic rf_we,
  input wire logic op_done,
  input wire logic trap,
  input wire logic [3:0] trap_cause
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  logic take, we_q;
  logic [31:0] ea_q;
  logic [7:0] asi_q;
  // Request accepted
  assign take = req_valid && req_ready;
  // Expected address and space of the accepted request
  always_ff @(posedge mclk) begin
    if (take) begin
      ea_q <= src_reg_a + ((req_alt || !req_use_imm) ? src_reg_b
        : {{19{signed_imm13[12]}}, signed_imm13});
      asi_q <= req_alt ? req_asi : (req_super ? LSU_ASI_SUPER : LSU_ASI_USER);
      we_q <= req_store;
    end
  end
  property p_one_outcome;
    take |-> ##2 (trap != mem_req);
  endproperty
  a_one_outcome: assert property (p_one_outcome)
    else $error("trap and memory access not exclusive");
  property p_priv_store;
    take && req_store && req_alt && !req_super
      |-> ##2 trap && trap_cause == LSU_TC_PRIV;
  endproperty
  a_priv_store: assert property (p_priv_store)
    else $error("user alternate store not privileged trap");
  property p_ill_store;
    take && req_store && req_alt && req_super && req_use_imm
      |-> ##2 trap && trap_cause == LSU_TC_ILL;
  endproperty
  a_ill_store: assert property (p_ill_store)
    else $error("alternate store with immediate not illegal");
  property p_priv_load;
    take && !req_store && req_alt && !req_super
      |-> ##2 trap && trap_cause == LSU_TC_PRIV;
  endproperty
  a_priv_load: assert property (p_priv_load)
    else $error("user alternate load not privileged trap");
  property p_addr;
    $rose(mem_req) |-> mem_addr == ea_q && mem_asi == asi_q && mem_we == we_q;
  endproperty
  a_addr: assert property (p_addr)
    else $error("memory address or space wrong");
  property p_dacc;
    mem_req && mem_ack && mem_access_err
      |=> trap && trap_cause == LSU_TC_DACC && !rf_we;
  endproperty
  a_dacc: assert property (p_dacc)
    else $error("access error not trapped");
  property p_trap_quiet;
    trap |-> !rf_we && !op_done;
  endproperty
  a_trap_quiet: assert property (p_trap_quiet)
    else $error("write or done alongside trap");
  property p_mem_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_mem_hold: assert property (p_mem_hold)
    else $error("memory request dropped or changed before ack");
  property p_dbl_next;
    mem_req && mem_ack ##1 mem_req |-> mem_addr == $past(mem_addr) + 32'h4;
  endproperty
  a_dbl_next: assert property (p_dbl_next)
    else $error("second word address not plus four");
  c_dbl: cover property (mem_req && mem_ack ##1 mem_req);
  c_dacc: cover property (mem_req && mem_ack && mem_access_err);
  c_ill: cover property (trap && trap_cause == LSU_TC_ILL);
endmodule : lsu_core_chk
bind lsu_core lsu_core_chk u_lsu_core_chk (.mclk, .rstn, .req_valid,
  .req_ready, .req_store, .req_alt, .req_use_imm, .req_super, .src_reg_a,
  .src_reg_b, .signed_imm13, .req_asi, .mem_req, .mem_we, .mem_addr,
  .mem_asi, .mem_ack, .mem_access_err, .rf_we, .op_done, .trap,
  .trap_cause);
`default_nettype wire

// ---- bench/load_store_unit_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module load_store_unit_bench
  import lsu_pkg::*;
;
  logic mclk, rstn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, req_asi, mem_asi;
  logic [31:0] pwdata, prdata, src_reg_a, src_reg_b, mem_addr, mem_rdata;
  logic [31:0] rf_data, seed, q;
  logic req_valid, req_ready, req_store, req_signed, req_alt, req_use_imm;
  logic req_super, fp_seq_err, cp_seq_err, fp_queue_not_empty;
  logic fpu_present_pin, coproc_present_pin, mem_req, mem_we, mem_ack;
  logic mem_access_err, rf_we, op_done, trap;
  logic [1:0] req_size, rf_sel, err_at;
  logic [2:0] req_unit, trap_ftt, lat;
  logic [12:0] signed_imm13;
  logic [4:0] req_rd, rf_idx;
  logic [3:0] trap_cause, ctrl;
  int fails = 0, checks = 0;
  lsu_core #(.APB_AW(8)) u_lsu_core (.mclk, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .req_valid, .req_ready,
    .req_store, .req_size, .req_signed, .req_alt, .req_unit, .req_use_imm,
    .req_super, .src_reg_a, .src_reg_b, .signed_imm13, .req_rd, .req_asi,
    .fp_seq_err, .cp_seq_err, .fp_queue_not_empty, .fpu_present_pin,
    .coproc_present_pin, .mem_req, .mem_we, .mem_addr, .mem_asi, .mem_ack,
    .mem_rdata, .mem_access_err, .rf_we, .rf_sel, .rf_idx, .rf_data,
    .op_done, .trap, .trap_cause, .trap_ftt);
  lsu_mem_model u_lsu_mem_model (.mclk, .mem_req, .mem_addr, .mem_ack,
    .mem_rdata, .mem_access_err, .lat, .err_at);
  // Clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 32; i++)
      s = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0);
    return s;
  endfunction : lfsr
  function automatic logic [31:0] mem_word(input logic [31:0] a);
    return {a[17:2], ~a[31:16]} ^ 32'h9e37_79b9;
  endfunction : mem_word
  // Loaded value after lane pick and extension
  function automatic logic [31:0] ld_val(input logic [31:0] ad);
    logic [31:0] w, sh;
    logic [15:0] h;
    w = mem_word(ad);
    sh = w >> {~ad[1:0], 3'h0};
    h = ad[1] ? w[15:0] : w[31:16];
    if (req_size == LSU_SZ_BYTE) return {{24{req_signed & sh[7]}}, sh[7:0]};
    if (req_size == LSU_SZ_HALF) return {{16{req_signed & h[15]}}, h};
    return w;
  endfunction : ld_val
  // Expected {ftt, cause} of the request now held
  function automatic logic [6:0] exp_res(input logic [31:0] ad);
    logic fpu, cpu, dbl, mis;
    fpu = req_unit inside {LSU_U_FP, LSU_U_FSR, LSU_U_FQ};
    cpu = req_unit inside {LSU_U_CP, LSU_U_CSR, LSU_U_CQ};
    dbl = req_size == LSU_SZ_DBL;
    mis = dbl ? ad[2:0] != 3'h0 : req_size == LSU_SZ_WORD ? ad[1:0] != 2'h0
      : req_size == LSU_SZ_HALF && ad[0];
    if (!req_super && (req_alt || req_unit inside {LSU_U_FQ, LSU_U_CQ}))
      return {LSU_FTT_NONE, LSU_TC_PRIV};
    if (req_alt && req_use_imm) return {LSU_FTT_NONE, LSU_TC_ILL};
    if (fpu && !(ctrl[0] && fpu_present_pin))
      return {LSU_FTT_NONE, LSU_TC_FPDIS};
    if (cpu && !(ctrl[1] && coproc_present_pin))
      return {LSU_FTT_NONE, LSU_TC_CPDIS};
    if (mis) return {LSU_FTT_NONE, LSU_TC_ALIGN};
    if (!req_store && req_unit == LSU_U_FP && dbl && req_rd[0])
      return {LSU_FTT_INVREG, LSU_TC_FPEXC};
    if (fpu && (req_store ? req_unit == LSU_U_FQ
        && !(ctrl[2] && fp_queue_not_empty) : fp_seq_err))
      return {LSU_FTT_SEQ, LSU_TC_FPEXC};
    if (cpu && (req_store ? req_unit == LSU_U_CQ && !ctrl[3] : cp_seq_err))
      return {LSU_FTT_NONE, LSU_TC_CPEXC};
    if (err_at == 2'h1 || (err_at == 2'h2 && dbl))
      return {LSU_FTT_NONE, LSU_TC_DACC};
    return {LSU_FTT_NONE, LSU_TC_NONE};
  endfunction : exp_res
  task automatic miss(input string m);
    fails++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : miss
  task automatic chk_word(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) miss($sformatf("word %h expected %h", g, x));
  endtask : chk_word
  task automatic chk_trap(input logic [6:0] g, input logic [6:0] x);
    checks++;
    if (g !== x) miss($sformatf("ftt/cause %h expected %h", g, x));
  endtask : chk_trap
  task automatic chk_rf(input logic [38:0] g, input logic [38:0] x);
    checks++;
    if (g !== x) miss($sformatf("reg write %h expected %h", g, x));
  endtask : chk_rf
  // One APB transfer: setup, access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One random operation, checked against the expectation
  task automatic run_op();
    logic [31:0] r, ad;
    logic [6:0] ex, gt;
    logic [38:0] wr[2], ew[2];
    logic [2:0] un;
    logic [1:0] sz, sel;
    int n, nw, en;
    r = lfsr(seed);
    seed = lfsr(r);
    un = r[8:6] == 3'h7 ? LSU_U_INT : r[8:6];
    if (!r[0] && un inside {LSU_U_FQ, LSU_U_CQ}) un = LSU_U_INT;
    sz = r[2:1];
    if (un inside {LSU_U_FSR, LSU_U_CSR}) sz = LSU_SZ_WORD;
    else if (un inside {LSU_U_FQ, LSU_U_CQ}) sz = LSU_SZ_DBL;
    else if (un != LSU_U_INT) sz = r[1] ? LSU_SZ_DBL : LSU_SZ_WORD;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_store <= r[0];
    req_size <= sz;
    req_unit <= un;
    req_signed <= r[3];
    req_alt <= r[4] & r[5] & (un == LSU_U_INT);
    req_use_imm <= r[9];
    req_super <= r[11] | r[12];
    req_rd <= {r[17:14], r[13] & ~r[0]};
    src_reg_a <= {seed[31:3], 3'h0};
    src_reg_b <= {29'h0, r[18:16] & {3{r[19]}}};
    signed_imm13 <= {{10{r[24]}}, r[23:21] & {3{r[19]}}};
    req_asi <= seed[10:3];
    fp_seq_err <= &r[27:25];
    cp_seq_err <= &r[29:27];
    fp_queue_not_empty <= r[28] | r[20];
    err_at <= r[31:30] == 2'h3 ? 2'h0 : r[31:30];
    lat <= seed[2:0];
    do @(posedge mclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    ad = src_reg_a + ((req_alt || !req_use_imm) ? src_reg_b
      : {{19{signed_imm13[12]}}, signed_imm13});
    ex = exp_res(ad);
    nw = 0;
    for (n = 0; n < 400; n++) begin
      @(posedge mclk);
      if (rf_we === 1'b1 && nw < 2) wr[nw++] = {rf_sel, rf_idx, rf_data};
      if (trap === 1'b1 || op_done === 1'b1) break;
    end
    if (n == 400) miss("operation never finished");
    gt = trap === 1'b1 ? {trap_ftt, trap_cause} : 7'h0;
    chk_trap(gt, ex);
    sel = un == LSU_U_CP ? LSU_RF_CP : un == LSU_U_FP ? LSU_RF_FP : LSU_RF_INT;
    en = 0;
    if (!req_store && un inside {LSU_U_INT, LSU_U_FP, LSU_U_CP} && err_at != 1
        && ex[3:0] inside {LSU_TC_NONE, LSU_TC_DACC}) begin
      if (sz == LSU_SZ_DBL) begin
        ew[en++] = {sel, req_rd[4:1], 1'b0, mem_word(ad)};
        if (err_at != 2'h2) ew[en++] = {sel, req_rd | 5'h1, mem_word(ad + 4)};
      end else if (!(un == LSU_U_INT && req_rd == 5'h0)) begin
        ew[en++] = {sel, req_rd, ld_val(ad)};
      end
    end
    chk_word(32'(nw), 32'(en));
    for (n = 0; n < en && n < nw; n++) chk_rf(wr[n], ew[n]);
    if (!req_store && un inside {LSU_U_FSR, LSU_U_CSR} && ex[3:0] == 0) begin
      apb(1'b0, un == LSU_U_FSR ? LSU_FSR_OFS : LSU_CSR_OFS, 32'h0);
      chk_word(q, mem_word(ad));
    end
  endtask : run_op
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // Watchdog
  initial begin
    repeat (60000) @(posedge mclk);
    miss("watchdog expired");
    tally_and_finish();
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, req_valid, req_store} = '0;
    {req_size, req_signed, req_alt, req_unit, req_use_imm, req_super} = '0;
    {src_reg_a, src_reg_b, signed_imm13, req_rd, req_asi} = '0;
    {fp_seq_err, cp_seq_err, fp_queue_not_empty, lat, err_at, ctrl} = '0;
    fpu_present_pin = 1'b1;
    coproc_present_pin = 1'b1;
    seed = 32'hbb4f20dd;
    rstn = 1'b0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    apb(1'b0, LSU_CTRL_OFS, 32'h0);
    chk_word(q, {28'h0, LSU_CTRL_RST});
    apb(1'b1, LSU_STAT_OFS, 32'hffff_ffff);
    apb(1'b0, LSU_STAT_OFS, 32'h0);
    chk_word(q, 32'h0);
    apb(1'b1, LSU_FSR_OFS, 32'h1234_5678);
    apb(1'b0, LSU_FSR_OFS, 32'h0);
    chk_word(q, 32'h1234_5678);
    apb(1'b0, 8'h10, 32'h0);
    chk_word({q[30:0], e}, 32'h1);
    for (int b = 0; b < 10; b++) begin
      seed = lfsr(seed);
      ctrl = seed[3:0] | {4{seed[4]}};
      fpu_present_pin <= seed[5] | seed[6];
      coproc_present_pin <= seed[7] | seed[8];
      apb(1'b1, LSU_CTRL_OFS, {28'h0, ctrl});
      apb(1'b0, LSU_CTRL_OFS, 32'h0);
      chk_word(q, {28'h0, ctrl});
      repeat (3) @(posedge mclk);
      repeat (30) run_op();
    end
    tally_and_finish();
  end
endmodule : load_store_unit_bench
`default_nettype wire
